// File: logic/psme_consts.svh
// Offsets, field positions, reset values and timing counts of the servo and periodic event block.
// Included by the design modules, the checker and the bench; holds definitions only.
`ifndef PSME_CONSTS_SVH
`define PSME_CONSTS_SVH

`define PSME_CLK_HZ        25000000
`define PSME_NS_PER_S      1000000000
`define PSME_NS_PER_CLK    (`PSME_NS_PER_S / `PSME_CLK_HZ)
`define PSME_TICK_NS       80
`define PSME_RATE_NUM      (`PSME_NS_PER_S / `PSME_TICK_NS)
`define PSME_EUI_FILL      16'hfffe

`define PSME_THR_10_NS     10000
`define PSME_THR_20_NS     20000
`define PSME_THR_100_NS    100000
`define PSME_THR_500_NS    500000
`define PSME_THR_1000_NS   1000000
`define PSME_THR_2000_NS   2000000

`define PSME_OFS_CTRL      8'h00
`define PSME_OFS_STATE     8'h04
`define PSME_OFS_MID_LO    8'h08
`define PSME_OFS_MID_HI    8'h0c
`define PSME_OFS_OFF_LO    8'h10
`define PSME_OFS_OFF_HI    8'h14
`define PSME_OFS_INTERVAL  8'h18
`define PSME_OFS_RATE      8'h1c
`define PSME_OFS_START_LO  8'h20
`define PSME_OFS_START_HI  8'h24
`define PSME_OFS_EFF_LO    8'h28
`define PSME_OFS_EFF_HI    8'h2c
`define PSME_OFS_TIME_LO   8'h30
`define PSME_OFS_TIME_HI   8'h34
`define PSME_OFS_IRQ_ST    8'h38
`define PSME_OFS_IRQ_MASK  8'h3c

`define PSME_CTRL_EN       0
`define PSME_CTRL_THR_LSB  1
`define PSME_CTRL_FRAME    4
`define PSME_ST_SERVO_LSB  0
`define PSME_ST_XPORT_LSB  2
`define PSME_ST_EVT_LSB    4

`define PSME_IRQ_MOD       0
`define PSME_IRQ_UNLOCK    1
`define PSME_IRQ_PORT      2
`define PSME_IRQ_FRAME     3

`define PSME_RST_THR       3'h0

`endif

// File: logic/psme_pkg.sv
// Types shared by the servo and periodic event block and its rate divider.
// Constants live in psme_consts.svh.
package psme_pkg;

    typedef enum logic [1:0] {
        PSME_UNLOCKED,
        PSME_SYNCING,
        PSME_LOCKED,
        PSME_INAPPLICABLE
    } psme_servo_t;

    typedef enum logic [4:0] {
        PSME_EV_NONE,
        PSME_EV_POWERUP,
        PSME_EV_INIT,
        PSME_EV_DESIG_EN,
        PSME_EV_DESIG_DIS,
        PSME_EV_FAULT_CLR,
        PSME_EV_FAULT_DET,
        PSME_EV_STATE_DEC,
        PSME_EV_QUAL_TO,
        PSME_EV_ANNC_TO,
        PSME_EV_SYNC_FAULT,
        PSME_EV_MASTER_SEL,
        PSME_EV_RS_MASTER,
        PSME_EV_RS_GRAND,
        PSME_EV_RS_SLAVE,
        PSME_EV_RS_PASSIVE
    } psme_port_evt_t;

    typedef struct packed {
        logic        busy;
        logic        done;
        logic [5:0]  cnt;
        logic [32:0] rem;
        logic [31:0] quo;
        logic [31:0] dvs;
    } psme_div_st_t;

    typedef struct packed {
        logic           pready;
        logic           pslverr;
        logic [31:0]    prdata;
        logic           servo_en;
        logic [2:0]     thr_sel;
        logic           frame_arm;
        psme_servo_t    servo;
        logic [63:0]    master_id;
        logic [63:0]    offset;
        psme_port_evt_t last_evt;
        logic [1:0]     transport;
        logic [31:0]    interval;
        logic [31:0]    rate;
        logic [63:0]    start;
        logic [63:0]    eff;
        logic           catchup;
        logic           armed;
        logic           frame_done;
        logic [63:0]    next_evt;
        logic [63:0]    now;
        logic [31:0]    slew;
        logic           div_go;
        logic [3:0]     irq_st;
        logic [3:0]     irq_mask;
        logic           irq;
        logic           mod_evt;
        logic           frame_trig;
    } psme_st_t;

endpackage

// File: logic/psme_rate_div.sv
// Restoring divider, one quotient bit per clock, used to turn the event interval into a rate.
// Assumes start is a one-cycle pulse and is not raised again while busy.
`timescale 1ns/1ps
`include "psme_consts.svh"

module psme_rate_div (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        start,
    input  wire logic [31:0] dividend,
    input  wire logic [31:0] divisor,
    output logic             done,
    output logic [31:0]      quotient
);
    import psme_pkg::*;

    psme_div_st_t s;
    psme_div_st_t next_s;
    logic [32:0]  trial;

    always_comb begin
        next_s = s;
        trial = {s.rem[31:0], s.quo[31]};
        next_s.done = 1'b0;
        if (start) begin
            next_s.busy = 1'b1;
            next_s.cnt = 6'h00;
            next_s.rem = 33'h0;
            next_s.quo = dividend;
            next_s.dvs = divisor;
        end else if (s.busy) begin
            next_s.quo = {s.quo[30:0], 1'b0};
            if (s.dvs != 32'h0 && trial >= {1'b0, s.dvs}) begin
                next_s.rem = trial - {1'b0, s.dvs};
                next_s.quo[0] = 1'b1;
            end else begin
                next_s.rem = trial;
            end
            next_s.cnt = s.cnt + 6'h01;
            if (s.cnt == 6'h1f) begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign done = s.done;
    assign quotient = s.quo;
endmodule

// File: logic/psme_servo_event.sv
// Slave clock servo status, master identity and offset, port event log and periodic event generator.
// Assumes offset samples, master address and port events come from logic on pclk; APB slave.
// How it works
// - Servo state reads as unlocked, synchronizing, locked or inapplicable.
// - Unlocked while the servo cannot yet follow the master.
// - Synchronizing while stepping local time toward the master.
// - Locked once only small frequency trims remain.
// - Master identity is the 48-bit address with 0xfffe inserted mid-way.
// - Latest signed master offset in ns, sampled only while the servo is enabled, readable as 64 bits.
// - Each offset sample drives the step or slew correction, except the one that leaves inapplicable and one that unlocks.
// - Most recent port state-change event code is logged.
// - Transport protocol code is readable.
// - Offset beyond step limit unlocks servo and restarts a step.
// - Step limit selects 10, 20, 100, 500, 1000 or 2000 us.
// - Periodic events are spaced by the configured interval.
// - Interval counts in 80 ns units.
// - Zero interval disables the periodic events.
// - Event rate in hertz is derived from the interval.
// - No events until the time counter exceeds the start time.
// - Start time also triggers a scheduled frame acquisition.
// - A past start is moved forward by whole intervals and reported.
`timescale 1ns/1ps
`include "psme_consts.svh"

module psme_servo_event (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     offset_valid,
    input  wire logic [63:0]              offset_ns,
    input  wire logic [47:0]              master_addr,
    input  wire logic                     port_event_valid,
    input  wire psme_pkg::psme_port_evt_t port_event_code,
    input  wire logic [1:0]               transport_code,
    output logic                          irq,
    output logic                          modulo_event,
    output logic                          frame_trigger,
    output logic [63:0]                   timestamp_ns
);
    import psme_pkg::*;

    psme_st_t    s;
    psme_st_t    next_s;
    logic        div_done;
    logic [31:0] div_quo;
    logic        take;
    logic        wr;
    logic [63:0] mag;
    logic [63:0] thr;
    logic [63:0] iv_ns;
    logic [3:0]  irq_set;
    logic [3:0]  irq_clr;
    logic        rd_ok;
    logic [31:0] rd_val;

    function automatic logic [63:0] abs64(input logic [63:0] v);
        return v[63] ? (~v + 64'h1) : v;
    endfunction

    function automatic logic [63:0] step_limit_ns(input logic [2:0] sel);
        unique case (sel)
            3'h0:    return 64'(`PSME_THR_10_NS);
            3'h1:    return 64'(`PSME_THR_20_NS);
            3'h2:    return 64'(`PSME_THR_100_NS);
            3'h3:    return 64'(`PSME_THR_500_NS);
            3'h4:    return 64'(`PSME_THR_1000_NS);
            default: return 64'(`PSME_THR_2000_NS);
        endcase
    endfunction

    psme_rate_div u_div (
        .pclk     (pclk),
        .presetn  (presetn),
        .start    (s.div_go),
        .dividend (32'(`PSME_RATE_NUM)),
        .divisor  (s.interval),
        .done     (div_done),
        .quotient (div_quo)
    );

    always_comb begin
        next_s = s;
        irq_set = 4'h0;
        irq_clr = 4'h0;
        take = psel & penable & s.pready;
        wr = take & pwrite;
        mag = abs64(offset_ns);
        thr = step_limit_ns(s.thr_sel);
        iv_ns = 64'(s.interval) * 64'(`PSME_TICK_NS);
        next_s.pready = psel & penable & ~s.pready;
        next_s.mod_evt = 1'b0;
        next_s.frame_trig = 1'b0;
        next_s.div_go = 1'b0;
        next_s.master_id = {master_addr[47:24], `PSME_EUI_FILL, master_addr[23:0]};
        next_s.transport = transport_code;

        // Slewing trims one ns per clock, so a locked clock never jumps backward
        if ($signed(s.slew) > 0) begin
            next_s.now = s.now + 64'(`PSME_NS_PER_CLK + 1);
            next_s.slew = s.slew - 32'h1;
        end else if ($signed(s.slew) < 0) begin
            next_s.now = s.now + 64'(`PSME_NS_PER_CLK - 1);
            next_s.slew = s.slew + 32'h1;
        end else begin
            next_s.now = s.now + 64'(`PSME_NS_PER_CLK);
        end

        if (!s.servo_en) begin
            next_s.servo = PSME_INAPPLICABLE;
            next_s.slew = 32'h0;
        end else if (offset_valid) begin
            next_s.offset = offset_ns;
            unique case (s.servo)
                PSME_INAPPLICABLE: begin
                    next_s.servo = PSME_UNLOCKED;
                end
                PSME_UNLOCKED: begin
                    // Step rides on the normal tick so the step cycle loses no time
                    next_s.now = next_s.now + offset_ns;
                    next_s.slew = 32'h0;
                    next_s.servo = PSME_SYNCING;
                end
                PSME_SYNCING: begin
                    if (mag <= thr) begin
                        next_s.slew = offset_ns[31:0];
                        next_s.servo = PSME_LOCKED;
                    end else begin
                        next_s.now = next_s.now + offset_ns;
                    end
                end
                PSME_LOCKED: begin
                    if (mag > thr) begin
                        next_s.servo = PSME_UNLOCKED;
                        next_s.slew = 32'h0;
                        irq_set[`PSME_IRQ_UNLOCK] = 1'b1;
                    end else begin
                        next_s.slew = offset_ns[31:0];
                    end
                end
            endcase
        end

        if (port_event_valid) begin
            next_s.last_evt = port_event_code;
            irq_set[`PSME_IRQ_PORT] = 1'b1;
        end

        if (div_done) begin
            next_s.rate = div_quo;
        end

        // A far past start walks forward one interval per clock until it lies ahead
        if (s.catchup) begin
            if (s.eff > s.now) begin
                next_s.catchup = 1'b0;
                next_s.armed = 1'b1;
                next_s.next_evt = s.eff;
            end else begin
                next_s.eff = s.eff + iv_ns;
            end
        end else if (s.armed && s.now > s.eff) begin
            if (s.interval != 32'h0 && s.now > s.next_evt) begin
                next_s.mod_evt = 1'b1;
                next_s.next_evt = s.next_evt + iv_ns;
                irq_set[`PSME_IRQ_MOD] = 1'b1;
            end
            if (s.frame_arm && !s.frame_done) begin
                next_s.frame_trig = 1'b1;
                next_s.frame_done = 1'b1;
                irq_set[`PSME_IRQ_FRAME] = 1'b1;
            end
        end

        rd_ok = 1'b1;
        rd_val = 32'h0;
        unique case (paddr)
            `PSME_OFS_CTRL:     rd_val = {27'h0, s.frame_arm, s.thr_sel, s.servo_en};
            `PSME_OFS_STATE:    rd_val = {23'h0, s.last_evt, s.transport, s.servo};
            `PSME_OFS_MID_LO:   rd_val = s.master_id[31:0];
            `PSME_OFS_MID_HI:   rd_val = s.master_id[63:32];
            `PSME_OFS_OFF_LO:   rd_val = s.offset[31:0];
            `PSME_OFS_OFF_HI:   rd_val = s.offset[63:32];
            `PSME_OFS_INTERVAL: rd_val = s.interval;
            `PSME_OFS_RATE:     rd_val = s.rate;
            `PSME_OFS_START_LO: rd_val = s.start[31:0];
            `PSME_OFS_START_HI: rd_val = s.start[63:32];
            `PSME_OFS_EFF_LO:   rd_val = s.eff[31:0];
            `PSME_OFS_EFF_HI:   rd_val = s.eff[63:32];
            `PSME_OFS_TIME_LO:  rd_val = s.now[31:0];
            `PSME_OFS_TIME_HI:  rd_val = s.now[63:32];
            `PSME_OFS_IRQ_ST:   rd_val = {28'h0, s.irq_st};
            `PSME_OFS_IRQ_MASK: rd_val = {28'h0, s.irq_mask};
            default:            rd_ok = 1'b0;
        endcase
        if (psel & penable & ~s.pready) begin
            next_s.prdata = pwrite ? 32'h0 : rd_val;
            next_s.pslverr = ~rd_ok;
        end

        if (wr) begin
            unique case (paddr)
                `PSME_OFS_CTRL: begin
                    next_s.servo_en = pwdata[`PSME_CTRL_EN];
                    next_s.thr_sel = pwdata[`PSME_CTRL_THR_LSB +: 3];
                    next_s.frame_arm = pwdata[`PSME_CTRL_FRAME];
                    if (pwdata[`PSME_CTRL_FRAME] && !s.frame_arm) begin
                        next_s.frame_done = 1'b0;
                    end
                end
                `PSME_OFS_INTERVAL: begin
                    next_s.interval = pwdata;
                    next_s.div_go = 1'b1;
                    next_s.armed = 1'b0;
                    next_s.catchup = 1'b1;
                    next_s.eff = s.start;
                end
                `PSME_OFS_START_LO: begin
                    next_s.start[31:0] = pwdata;
                end
                `PSME_OFS_START_HI: begin
                    // Writing the upper word arms the start so both halves land together
                    next_s.start[63:32] = pwdata;
                    next_s.eff = {pwdata, s.start[31:0]};
                    next_s.armed = 1'b0;
                    next_s.catchup = 1'b1;
                    next_s.frame_done = 1'b0;
                end
                `PSME_OFS_IRQ_ST: begin
                    irq_clr = pwdata[3:0];
                end
                `PSME_OFS_IRQ_MASK: begin
                    next_s.irq_mask = pwdata[3:0];
                end
                default: begin
                end
            endcase
        end

        // A zero interval must not stall the walk forward; the start is then used as given
        if (next_s.catchup && next_s.interval == 32'h0) begin
            next_s.catchup = 1'b0;
            next_s.armed = 1'b1;
            next_s.next_evt = next_s.eff;
        end

        // Set beats clear so an event in the clearing cycle survives
        next_s.irq_st = (s.irq_st & ~irq_clr) | irq_set;
        next_s.irq = |(next_s.irq_st & next_s.irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.servo <= PSME_INAPPLICABLE;
            s.last_evt <= PSME_EV_NONE;
            s.thr_sel <= `PSME_RST_THR;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign irq = s.irq;
    assign modulo_event = s.mod_evt;
    assign frame_trigger = s.frame_trig;
    assign timestamp_ns = s.now;
endmodule

// File: test/psme_servo_event_properties.sv
// Port-level checks of the servo and periodic event block.
// Bound into psme_servo_event from the bench top; single pclk domain.
`timescale 1ns/1ps
`include "psme_consts.svh"

module psme_servo_event_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        offset_valid,
    input wire logic [47:0] master_addr,
    input wire logic [1:0]  transport_code,
    input wire logic        irq,
    input wire logic        modulo_event,
    input wire logic        frame_trigger,
    input wire logic [63:0] timestamp_ns
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ready_one_shot_a: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    ready_wait_state_a: assert property (psel && penable && !pready |=> pready)
        else $error("access did not end after one wait state");
    unmapped_err_a: assert property (pready && paddr > 8'h3c |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    // Slew may bend a tick by 1 ns; anything else means the counter stalled or jumped
    time_steady_a: assert property (presetn && $past(presetn) && !offset_valid
        |=> (timestamp_ns - $past(timestamp_ns)) inside {64'd39, 64'd40, 64'd41})
        else $error("time counter step outside one tick");
    master_id_hi_a: assert property (pready && !pwrite && paddr == `PSME_OFS_MID_HI && $stable(master_addr)
        && master_addr == $past(master_addr, 2) |-> prdata == {master_addr[47:24], 8'hff})
        else $error("master identity high word wrong");
    master_id_lo_a: assert property (pready && !pwrite && paddr == `PSME_OFS_MID_LO && $stable(master_addr)
        && master_addr == $past(master_addr, 2) |-> prdata == {8'hfe, master_addr[23:0]})
        else $error("master identity low word wrong");
    state_fields_a: assert property (pready && !pwrite && paddr == `PSME_OFS_STATE && $stable(transport_code)
        && transport_code == $past(transport_code, 2)
        |-> prdata[3:2] == transport_code && prdata[31:9] == 23'h0)
        else $error("state word transport or reserved bits wrong");
    frame_once_a: assert property (frame_trigger |=> !frame_trigger [*4])
        else $error("frame trigger repeated");
    irq_clear_a: assert property ($fell(irq) |-> $past(pready && pwrite) || $past(pready && pwrite, 2))
        else $error("interrupt fell without a register write");

    cover property (modulo_event);
    cover property (frame_trigger);
    cover property (pready && pslverr);
    cover property ($rose(irq));
endmodule

// File: test/psme_master_model.sv
// Stand-in for the network master clock and port logic feeding offset samples and events.
// Tasks are called by the bench right after a rising pclk edge.
`timescale 1ns/1ps

module psme_master_model #(
    parameter logic [47:0] MASTER_ADDR = 48'h0a1b2c3d4e5f // Arbitrary address
) (
    input  wire logic                pclk,
    output logic                     offset_valid,
    output logic [63:0]              offset_ns,
    output logic [47:0]              master_addr,
    output logic                     port_event_valid,
    output psme_pkg::psme_port_evt_t port_event_code,
    output logic [1:0]               transport_code
);
    import psme_pkg::*;

    initial begin
        offset_valid = 1'b0;
        offset_ns = 64'h0;
        master_addr = MASTER_ADDR;
        port_event_valid = 1'b0;
        port_event_code = PSME_EV_NONE;
        transport_code = 2'h0;
    end

    // A spent sample shows its inverse so a stale value never passes as fresh
    task automatic send_offset(input logic [63:0] v);
        offset_valid <= 1'b1;
        offset_ns <= v;
        @(posedge pclk);
        offset_valid <= 1'b0;
        offset_ns <= ~v;
        @(posedge pclk);
    endtask

    task automatic send_event(input psme_port_evt_t c, input logic [1:0] x);
        port_event_valid <= 1'b1;
        port_event_code <= c;
        transport_code <= x;
        @(posedge pclk);
        port_event_valid <= 1'b0;
        port_event_code <= psme_port_evt_t'(~c);
        @(posedge pclk);
    endtask
endmodule

// File: test/psme_servo_event_tb.sv
// Directed bench: APB register access, servo sequences and periodic event timing.
// Assumes the master model drives the network side; the checker is bound below.
`timescale 1ns/1ps
`include "psme_consts.svh"
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin errors++; \
    $display("unexpected %s: expected %0h, seen %0h", n, e, s); end end

module psme_servo_event_tb;
    import psme_pkg::*;
    logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic           modulo_event, frame_trigger, offset_valid, port_event_valid;
    logic [7:0]     paddr;
    logic [31:0]    pwdata, prdata, rd_v;
    logic [63:0]    timestamp_ns, offset_ns, t0, st, frt;
    logic [47:0]    master_addr;
    logic [1:0]     transport_code;
    psme_port_evt_t port_event_code;
    logic [63:0]    evq[$];
    logic [63:0]    lim[6] = '{`PSME_THR_10_NS, `PSME_THR_20_NS, `PSME_THR_100_NS,
                               `PSME_THR_500_NS, `PSME_THR_1000_NS, `PSME_THR_2000_NS};
    int             errors, n_compared, cyc, nfr;

    psme_servo_event psme_servo_event_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .offset_valid(offset_valid), .offset_ns(offset_ns), .master_addr(master_addr),
        .port_event_valid(port_event_valid), .port_event_code(port_event_code),
        .transport_code(transport_code), .irq(irq), .modulo_event(modulo_event),
        .frame_trigger(frame_trigger), .timestamp_ns(timestamp_ns));
    psme_master_model psme_master_model_inst (.pclk(pclk), .offset_valid(offset_valid), .offset_ns(offset_ns),
        .master_addr(master_addr), .port_event_valid(port_event_valid), .port_event_code(port_event_code),
        .transport_code(transport_code));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Pulse log and hang guard; the run needs little more than a thousand cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (modulo_event === 1'b1) evq.push_back(timestamp_ns);
        if (frame_trigger === 1'b1) begin
            nfr++;
            frt = timestamp_ns;
        end
        if (cyc == 20000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_v = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    initial begin
        errors = 0;
        n_compared = 0;
        cyc = 0;
        nfr = 0;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `PSME_OFS_STATE, 0);
        `CHK("state after reset", {28'h0, transport_code, 2'h3}, rd_v)
        apb(0, `PSME_OFS_MID_LO, 0);
        `CHK("id low", {8'hfe, master_addr[23:0]}, rd_v)
        apb(0, `PSME_OFS_MID_HI, 0);
        `CHK("id high", {master_addr[47:24], 8'hff}, rd_v)
        apb(0, 8'h40, 0);
        `CHK("unmapped read", 33'h100000000, {err, rd_v})
        apb(1, 8'h40, 32'h5a5a5a5a);
        `CHK("unmapped write", 1'b1, err)
        for (int i = 0; i < 16; i++) begin
            psme_master_model_inst.send_event(psme_port_evt_t'(i), i[1:0]);
            apb(0, `PSME_OFS_STATE, 0);
            `CHK("port event", 5'(i), rd_v[8:4])
            `CHK("transport", i[1:0], rd_v[3:2])
        end
        // Interrupt: raise, mask, unmask, clear
        apb(1, `PSME_OFS_IRQ_MASK, 32'h4);
        apb(0, `PSME_OFS_IRQ_ST, 0);
        `CHK("event flag", 32'h4, rd_v)
        `CHK("irq raised", 1'b1, irq)
        apb(1, `PSME_OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge pclk);
        `CHK("irq masked", 1'b0, irq)
        apb(1, `PSME_OFS_IRQ_MASK, 32'h4);
        apb(1, `PSME_OFS_IRQ_ST, 32'h4);
        repeat (2) @(posedge pclk);
        `CHK("irq cleared", 1'b0, irq)
        // Periodic events
        apb(0, `PSME_OFS_RATE, 0);
        `CHK("rate idle", 32'h0, rd_v)
        apb(1, `PSME_OFS_INTERVAL, 32'h5);
        repeat (40) @(posedge pclk);
        apb(0, `PSME_OFS_RATE, 0);
        `CHK("rate", 32'(`PSME_RATE_NUM / 5), rd_v)
        st = timestamp_ns + 64'd4000;
        apb(1, `PSME_OFS_START_LO, st[31:0]);
        apb(1, `PSME_OFS_START_HI, st[63:32]);
        apb(1, `PSME_OFS_CTRL, 32'h10);
        evq.delete();
        nfr = 0;
        apb(0, `PSME_OFS_EFF_LO, 0);
        `CHK("future start", st[31:0], rd_v)
        repeat (200) @(posedge pclk);
        `CHK("frame pulses", 1, nfr)
        `CHK("frame time", 1'b1, frt > st && frt <= st + 64'd80)
        `CHK("first event", 1'b1, evq[0] > st && evq[0] <= st + 64'd80)
        for (int i = 1; i < evq.size(); i++) `CHK("spacing", 64'd400, evq[i] - evq[i-1])
        apb(1, `PSME_OFS_START_LO, 0);
        t0 = timestamp_ns;
        apb(1, `PSME_OFS_START_HI, 0);
        repeat (400) @(posedge pclk);
        apb(0, `PSME_OFS_EFF_LO, 0);
        `CHK("late start grid", 32'h0, rd_v % 400)
        `CHK("late start ahead", 1'b1, rd_v > t0[31:0])
        apb(1, `PSME_OFS_INTERVAL, 0);
        repeat (3) @(posedge pclk);
        evq.delete();
        repeat (100) @(posedge pclk);
        `CHK("events when off", 0, evq.size())
        // Servo walk, then each step limit at and just over its edge
        apb(1, `PSME_OFS_CTRL, 32'h1);
        psme_master_model_inst.send_offset(64'd20000);
        apb(0, `PSME_OFS_STATE, 0);
        `CHK("unlocked", 2'h0, rd_v[1:0])
        t0 = timestamp_ns;
        psme_master_model_inst.send_offset(64'd5000);
        `CHK("step", 64'd5080, timestamp_ns - t0)
        apb(0, `PSME_OFS_STATE, 0);
        `CHK("syncing", 2'h1, rd_v[1:0])
        psme_master_model_inst.send_offset(-64'sd300);
        apb(0, `PSME_OFS_STATE, 0);
        `CHK("locked", 2'h2, rd_v[1:0])
        apb(0, `PSME_OFS_OFF_LO, 0);
        `CHK("offset low", 32'hfffffed4, rd_v)
        apb(0, `PSME_OFS_OFF_HI, 0);
        `CHK("offset high", 32'hffffffff, rd_v)
        for (int s = 0; s < 6; s++) begin
            apb(1, `PSME_OFS_CTRL, {28'h0, s[2:0], 1'b1});
            apb(1, `PSME_OFS_IRQ_ST, 32'hf);
            psme_master_model_inst.send_offset(lim[s]);
            apb(0, `PSME_OFS_STATE, 0);
            `CHK("at limit", 2'h2, rd_v[1:0])
            psme_master_model_inst.send_offset(lim[s] + 64'd1);
            apb(0, `PSME_OFS_STATE, 0);
            `CHK("over limit", 2'h0, rd_v[1:0])
            apb(0, `PSME_OFS_IRQ_ST, 0);
            `CHK("unlock flag", 1'b1, rd_v[1])
            psme_master_model_inst.send_offset(lim[s]);
            psme_master_model_inst.send_offset(64'd0);
        end
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `PSME_OFS_STATE, 0);
        `CHK("state after second reset", {28'h0, transport_code, 2'h3}, rd_v)
        wrap_up();
    end
endmodule

bind psme_servo_event psme_servo_event_properties psme_servo_event_properties_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .offset_valid(offset_valid), .master_addr(master_addr),
    .transport_code(transport_code), .irq(irq), .modulo_event(modulo_event),
    .frame_trigger(frame_trigger), .timestamp_ns(timestamp_ns));
